//--- tb_timer_counter_input_capture.sv
// testbench: register-port sequences against the timer with input capture
// assumes tcic_timer, tcic_pin_model and tcic_timer_props are compiled first
`timescale 1ns/1ps
module tb_timer_counter_input_capture;
   import tcic_pkg::*;
   // ************************************************
   // stimulus, tasks and test sequence
   // ************************************************
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   tcic_bus_req_t req = '0;
   logic bg = 1'b0;
   logic stop = 1'b0;
   logic ext = 1'b0;
   logic [1:0] fire = 2'h0;
   wire logic [7:0] rdata;
   wire logic [1:0] pins;
   wire logic [1:0] irq_c;
   wire logic [1:0] own;
   wire logic irq_o;
   int bad_count = 0;
   int num_checks = 0;
   logic [15:0] va, vb, vc;
   logic [7:0] x, h, l;

   // 100 ns bus clock
   initial forever #50 clk = ~clk;

   tcic_timer dut_u (.clk(clk), .sys_rst(sys_rst), .bus_req(req), .rdata(rdata), .chan_pin_in(pins),
      .background_active(bg), .stop_mode(stop), .overflow_irq(irq_o), .chan_irq(irq_c), .chan_pin_own(own));
   tcic_pin_model pin_u (.clk(clk), .sys_rst(sys_rst), .fire(fire), .ext_run(ext), .pin(pins));

   task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         bad_count++;
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // one request per call; a quiet cycle between calls avoids double drives
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk) req <= '0;
      #1;
   endtask
   task rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) req <= '0;
      #1 d = rdata;
   endtask
   task rd16(input logic [3:0] a, output logic [15:0] v);
      logic [7:0] hb, lb;
      rd(a, hb);
      rd(a + 4'h1, lb);
      v = {hb, lb};
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // two counter samples whose high-byte strobes lie k cycles apart
   task meas(input int k);
      rd16(TCIC_ADDR_CNT_HI, va);
      cyc(k - 4);
      rd16(TCIC_ADDR_CNT_HI, vb);
   endtask
   // look just after each edge so the flop update has landed
   task wait_ovf;
      for (int i = 0; i < 40 && irq_o !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      if (irq_o !== 1'b1) begin
         $display("[FAIL] overflow wait expected 1 seen %b", irq_o);
         bad_count++;
         give_verdict;
      end
   endtask

   // main sequence; windows allow for the pin synchroniser delay
   initial begin
      cyc(10);
      sys_rst <= 1'b0;
      rd(TCIC_ADDR_SC, x);
      chk("status", 16'h0000, {8'h00, x});
      meas(16);
      chk("count off", 16'h0000, vb);
      for (int c = 1; c < 3; c++) for (int p = 0; p < 8; p++) begin
         wr(TCIC_ADDR_SC, 8'(c * 8 + p));
         meas(8 << p);
         chk("prescale", 16'h0008, vb - va);
      end
      // undivided bus clock, so a broken pause shows up within the window
      wr(TCIC_ADDR_SC, 8'h08);
      for (int m = 0; m < 2; m++) begin
         @(posedge clk) {stop, bg} <= 2'(1 << m);
         cyc(2);
         meas(16);
         chk("paused", 16'h0000, vb - va);
      end
      @(posedge clk) {stop, bg} <= 2'h0;
      wr(TCIC_ADDR_SC, 8'h18);
      @(posedge clk) ext <= 1'b1;
      cyc(16);
      meas(64);
      chk("ext clock", 16'h0008, vb - va);
      @(posedge clk) ext <= 1'b0;
      wr(TCIC_ADDR_SC, 8'h08);
      rd(TCIC_ADDR_CNT_HI, h);
      cyc(16);
      rd(TCIC_ADDR_CNT_LO, l);
      rd16(TCIC_ADDR_CNT_HI, vc);
      chk("count latch", 16'h0014, vc - {h, l});
      rd(TCIC_ADDR_CNT_HI, h);
      wr(TCIC_ADDR_CNT_LO, 8'hA5);
      rd16(TCIC_ADDR_CNT_HI, vc);
      chk("count clear", 16'h0001, {15'h0, vc < 16'h0008});
      wr(TCIC_ADDR_SC, 8'h48);
      wr(TCIC_ADDR_MOD_HI, 8'h00);
      wr(TCIC_ADDR_MOD_LO, 8'h09);
      wr(TCIC_ADDR_CNT_HI, 8'h00);
      wait_ovf;
      meas(10);
      chk("mod wrap", 16'h0000, vb - va);
      chk("mod range", 16'h0001, {15'h0, vb < 16'h000A});
      wr(TCIC_ADDR_SC, 8'hC0);
      for (int i = 0; i < 3; i++) begin
         wr(TCIC_ADDR_SC, (i == 0) ? 8'h80 : (i == 1) ? 8'hC0 : 8'h40);
         chk("ovf irq", 16'(i != 0), {15'h0, irq_o});
      end
      rd(TCIC_ADDR_SC, x);
      chk("status", 16'h00C0, {8'h00, x});
      wr(TCIC_ADDR_SC, 8'h40);
      chk("ovf clear", 16'h0000, {15'h0, irq_o});
      wr(TCIC_ADDR_SC, 8'h68);
      wr(TCIC_ADDR_MOD_HI, 8'h00);
      wr(TCIC_ADDR_MOD_LO, 8'h04);
      wr(TCIC_ADDR_CNT_HI, 8'h00);
      chk("pin own", 16'h0003, {14'h0, own});
      wait_ovf;
      meas(8);
      chk("center period", 16'h0000, vb - va);
      meas(4);
      chk("center mirror", 16'h0004, vb + va);
      wr(TCIC_ADDR_SC, 8'h08);
      wr(TCIC_ADDR_MOD_HI, 8'h00);
      wr(TCIC_ADDR_MOD_LO, 8'h00);
      for (int n = 0; n < 2; n++) for (int e = 1; e < 4; e++) begin
         rd(4'(5 + 3 * n), x);
         wr(4'(5 + 3 * n), 8'(64 + e * 4));
         rd16(TCIC_ADDR_CNT_HI, va);
         @(posedge clk) fire <= 2'(1 << n);
         @(posedge clk) fire <= 2'h0;
         cyc(10);
         chk("rise flag", 16'(e != 2), {15'h0, irq_c[n]});
         cyc(20);
         chk("fall flag", 16'h0001, {15'h0, irq_c[n]});
         rd16(4'(6 + 3 * n), vc);
         vc = vc - va - ((e == 1) ? 16'h0005 : 16'h0019);
         chk("capture time", 16'h0001, {15'h0, vc < 16'h0009});
      end
      wr(TCIC_ADDR_CH0, 8'h00);
      chk("pin own", 16'h0002, {14'h0, own});
      // channel 1 as output compare: no edge bits, yet it keeps the pin and flags on a match
      rd(4'h8, x);
      wr(4'h9, 8'h00);
      wr(4'hA, 8'h30);
      wr(4'h8, 8'h50);
      chk("pin own", 16'h0002, {14'h0, own});
      wr(TCIC_ADDR_CNT_HI, 8'h00);
      chk("cmp flag", 16'h0000, {15'h0, irq_c[1]});
      cyc(60);
      chk("cmp flag", 16'h0001, {15'h0, irq_c[1]});
      @(posedge clk) sys_rst <= 1'b1;
      cyc(3);
      @(posedge clk) sys_rst <= 1'b0;
      rd(TCIC_ADDR_SC, x);
      chk("status", 16'h0000, {8'h00, x});
      give_verdict;
   end
endmodule

bind tcic_timer tcic_timer_props props_u (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata),
   .chan_pin_in(chan_pin_in), .background_active(background_active), .stop_mode(stop_mode),
   .overflow_irq(overflow_irq), .chan_irq(chan_irq), .chan_pin_own(chan_pin_own));

//--- tcic_pin_model.sv
// pin-side stand-in: event pulses on the channel pins and a slow external clock
// assumes it runs on the bus clock and is reset with the timer
`timescale 1ns/1ps
module tcic_pin_model
   import tcic_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [TCIC_NUM_CHAN-1:0] fire,
   input wire logic ext_run,
   output logic [TCIC_NUM_CHAN-1:0] pin
);
   // ************************************************
   // pulse and clock generation
   // ************************************************
   logic [4:0] left0_q;
   logic [4:0] left1_q;
   logic [2:0] phase_q;

   // pulses last 20 cycles so both edges stay apart after synchronising
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         left0_q <= 5'h00;
         left1_q <= 5'h00;
         phase_q <= 3'h0;
      end else begin
         phase_q <= phase_q + 3'h1;
         left0_q <= fire[0] ? 5'h14 : left0_q - {4'h0, left0_q != 5'h00};
         left1_q <= fire[1] ? 5'h14 : left1_q - {4'h0, left1_q != 5'h00};
      end
   end

   // clock period of eight bus cycles, under a quarter of the bus rate
   assign pin[0] = ext_run ? phase_q[2] : (left0_q != 5'h00);
   assign pin[1] = left1_q != 5'h00;
endmodule

//--- tcic_pkg.sv
// constants, register map and carrier types for the timer with input capture
// assumes a byte-wide register port and two capture channels
package tcic_pkg;

   // ***************************************************
   // sizes
   // ***************************************************
   localparam int unsigned TCIC_NUM_CHAN = 2;

   // ***************************************************
   // register offsets (byte wide)
   // ***************************************************
   localparam logic [3:0] TCIC_ADDR_SC = 4'h0;
   localparam logic [3:0] TCIC_ADDR_CNT_HI = 4'h1;
   localparam logic [3:0] TCIC_ADDR_CNT_LO = 4'h2;
   localparam logic [3:0] TCIC_ADDR_MOD_HI = 4'h3;
   localparam logic [3:0] TCIC_ADDR_MOD_LO = 4'h4;
   localparam logic [3:0] TCIC_ADDR_CH0 = 4'h5;
   localparam logic [3:0] TCIC_CH_STRIDE = 4'h3;
   localparam logic [3:0] TCIC_CH_OFS_SC = 4'h0;
   localparam logic [3:0] TCIC_CH_OFS_VH = 4'h1;
   localparam logic [3:0] TCIC_CH_OFS_VL = 4'h2;

   // ***************************************************
   // field positions
   // ***************************************************
   localparam int unsigned TCIC_SC_OVF = 7;
   localparam int unsigned TCIC_SC_OVF_IE = 6;
   localparam int unsigned TCIC_SC_CENTER = 5;
   localparam int unsigned TCIC_SC_CLK_HI = 4;
   localparam int unsigned TCIC_SC_CLK_LO = 3;
   localparam int unsigned TCIC_SC_PS_HI = 2;
   localparam int unsigned TCIC_SC_PS_LO = 0;
   localparam int unsigned TCIC_CH_FLAG = 7;
   localparam int unsigned TCIC_CH_IE = 6;
   localparam int unsigned TCIC_CH_MODE_HI = 5;
   localparam int unsigned TCIC_CH_MODE_LO = 4;
   localparam int unsigned TCIC_CH_EDGE_HI = 3;
   localparam int unsigned TCIC_CH_EDGE_LO = 2;

   // ***************************************************
   // codes and values
   // ***************************************************
   localparam logic [1:0] TCIC_CLK_OFF = 2'h0;
   localparam logic [1:0] TCIC_CLK_BUS = 2'h1;
   localparam logic [1:0] TCIC_CLK_FIXED = 2'h2;
   localparam logic [1:0] TCIC_CLK_EXT = 2'h3;
   localparam logic [1:0] TCIC_MODE_CAPTURE = 2'h0;
   localparam logic [1:0] TCIC_EDGE_NONE = 2'h0;
   localparam logic [1:0] TCIC_EDGE_RISE = 2'h1;
   localparam logic [1:0] TCIC_EDGE_FALL = 2'h2;
   localparam logic [1:0] TCIC_EDGE_ANY = 2'h3;
   localparam logic [15:0] TCIC_CNT_ZERO = 16'h0000;
   localparam logic [15:0] TCIC_CNT_ONE = 16'h0001;
   localparam logic [15:0] TCIC_CNT_MAX = 16'hFFFF;
   localparam logic [6:0] TCIC_PRE_ZERO = 7'h00;
   localparam logic [6:0] TCIC_PRE_ONE = 7'h01;
   localparam logic [7:0] TCIC_BYTE_ZERO = 8'h00;
   localparam logic [1:0] TCIC_GOT_NONE = 2'h0;
   localparam logic [1:0] TCIC_GOT_BOTH = 2'h3;

   // ***************************************************
   // carrier types
   // ***************************************************
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tcic_bus_req_t;

   typedef struct packed {
      logic irq_en;
      logic [1:0] mode_sel;
      logic [1:0] edge_sel;
   } tcic_chan_cfg_t;

endpackage

//--- tcic_timer.sv
// 16-bit timer with prescaler, modulus, up or up/down counting and input capture
// assumes a byte register port with read data one cycle after the read strobe,
// and pins asynchronous inputs, all of them resynchronised here, the external clock included
`timescale 1ns/1ps
module tcic_timer
   import tcic_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire tcic_bus_req_t bus_req,
   output logic [7:0] rdata,
   input wire logic [TCIC_NUM_CHAN-1:0] chan_pin_in,
   input wire logic background_active,
   input wire logic stop_mode,
   output logic overflow_irq,
   output logic [TCIC_NUM_CHAN-1:0] chan_irq,
   output logic [TCIC_NUM_CHAN-1:0] chan_pin_own
);

   // ***************************************************
   // helpers
   // ***************************************************
   // byte address of one channel register
   function automatic logic [3:0] chan_addr(input int n, input logic [3:0] ofs);
      logic [3:0] base;
      base = TCIC_ADDR_CH0 + 4'(n) * TCIC_CH_STRIDE;
      return 4'(base + ofs);
   endfunction

   // low prescaler bits that must all be one for an output pulse
   function automatic logic [6:0] pre_mask(input logic [2:0] sel);
      logic [7:0] m;
      m = (8'h01 << sel) - 8'h01;
      return m[6:0];
   endfunction

   // edge detector on the synchronised pin
   function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic prev);
      logic rise;
      logic fall;
      rise = now & ~prev;
      fall = ~now & prev;
      case (sel)
         TCIC_EDGE_RISE: return rise;
         TCIC_EDGE_FALL: return fall;
         TCIC_EDGE_ANY: return rise | fall;
         default: return 1'b0;
      endcase
   endfunction

   // ***************************************************
   // state
   // ***************************************************
   logic ovf_q, ovf_ie_q, center_q, ovf_arm_q;
   logic [1:0] clk_sel_q;
   logic [2:0] ps_sel_q;
   logic [6:0] pre_q;
   logic [15:0] cnt_q, mod_q, mod_buf_q, cnt_buf_q;
   logic [1:0] mod_got_q, cnt_got_q;
   logic cnt_lat_q, dir_down_q;
   logic [TCIC_NUM_CHAN-1:0] pin_s1_q, pin_s2_q, pin_s3_q;
   tcic_chan_cfg_t cfg_q [TCIC_NUM_CHAN];
   logic [TCIC_NUM_CHAN-1:0] chf_q, ch_arm_q, val_lat_q;
   logic [15:0] val_q [TCIC_NUM_CHAN];
   logic [15:0] val_buf_q [TCIC_NUM_CHAN];
   logic [1:0] val_got_q [TCIC_NUM_CHAN];
   logic [7:0] rdata_q;

   // ***************************************************
   // register decode
   // ***************************************************
   wire logic wr = bus_req.wr;
   wire logic rd = bus_req.rd;
   wire logic [3:0] addr = bus_req.addr;
   wire logic [7:0] wdata = bus_req.wdata;
   wire logic hit_sc = addr == TCIC_ADDR_SC;
   wire logic hit_chi = addr == TCIC_ADDR_CNT_HI;
   wire logic hit_clo = addr == TCIC_ADDR_CNT_LO;
   wire logic hit_mhi = addr == TCIC_ADDR_MOD_HI;
   wire logic hit_mlo = addr == TCIC_ADDR_MOD_LO;
   wire logic sc_wr = wr & hit_sc;
   wire logic cnt_wr = wr & (hit_chi | hit_clo);
   wire logic cnt_rd = rd & (hit_chi | hit_clo);
   logic [TCIC_NUM_CHAN-1:0] hit_csc, hit_cvh, hit_cvl;

   // per-channel address decode
   for (genvar g = 0; g < TCIC_NUM_CHAN; g++) begin : g_dec
      assign hit_csc[g] = addr == chan_addr(g, TCIC_CH_OFS_SC);
      assign hit_cvh[g] = addr == chan_addr(g, TCIC_CH_OFS_VH);
      assign hit_cvl[g] = addr == chan_addr(g, TCIC_CH_OFS_VL);
   end

   // ***************************************************
   // clock source and prescaler
   // ***************************************************
   // the fixed clock does not exist here, so it falls back to the bus clock
   wire logic ext_rise = pin_s2_q[0] & ~pin_s3_q[0];
   wire logic halt = background_active | stop_mode;
   wire logic bus_src = (clk_sel_q == TCIC_CLK_BUS) | (clk_sel_q == TCIC_CLK_FIXED);
   wire logic ext_src = (clk_sel_q == TCIC_CLK_EXT) & ext_rise;
   wire logic src_tick = ~halt & (bus_src | ext_src);
   wire logic [6:0] mask = pre_mask(ps_sel_q);
   wire logic cnt_tick = src_tick & ((pre_q & mask) == mask);

   // ***************************************************
   // counter next value
   // ***************************************************
   // center mode with a zero modulus cannot reverse, so it falls back to up counting
   wire logic updown = center_q & (mod_q != TCIC_CNT_ZERO);
   wire logic [15:0] term = (mod_q == TCIC_CNT_ZERO) ? TCIC_CNT_MAX : mod_q;
   wire logic up_wrap = (cnt_q == term) | (cnt_q == TCIC_CNT_MAX);
   wire logic turn_dn = ~dir_down_q & (cnt_q >= mod_q);
   wire logic turn_up = dir_down_q & (cnt_q == TCIC_CNT_ZERO);
   logic [15:0] cnt_nxt;
   logic dir_nxt;

   // next count for the active counting mode
   always_comb begin
      cnt_nxt = 16'(cnt_q + TCIC_CNT_ONE);
      dir_nxt = 1'b0;
      if (!updown) begin
         if (up_wrap) begin
            cnt_nxt = TCIC_CNT_ZERO;
         end
      end else if (turn_dn) begin
         cnt_nxt = 16'(cnt_q - TCIC_CNT_ONE);
         dir_nxt = 1'b1;
      end else if (turn_up) begin
         cnt_nxt = TCIC_CNT_ONE;
      end else if (dir_down_q) begin
         cnt_nxt = 16'(cnt_q - TCIC_CNT_ONE);
         dir_nxt = 1'b1;
      end
   end

   // overflow event; a counter write in the same cycle wins over the count
   wire logic ovf_evt = cnt_tick & ~cnt_wr & (updown ? turn_dn : up_wrap);

   // ***************************************************
   // channel events
   // ***************************************************
   logic [TCIC_NUM_CHAN-1:0] cap_evt, cmp_evt, ch_evt, capture_md;

   for (genvar g = 0; g < TCIC_NUM_CHAN; g++) begin : g_evt
      // center mode overrides the per-channel mode bits
      assign capture_md[g] = ~center_q & (cfg_q[g].mode_sel == TCIC_MODE_CAPTURE);
      assign cap_evt[g] = capture_md[g] & edge_hit(cfg_q[g].edge_sel, pin_s2_q[g], pin_s3_q[g]);
      assign cmp_evt[g] = ~capture_md[g] & cnt_tick & ~cnt_wr & (cnt_nxt == val_q[g]);
      assign ch_evt[g] = cap_evt[g] | cmp_evt[g];
      // while the timer claims the pin, the port registers have no say
      assign chan_pin_own[g] = (cfg_q[g].edge_sel != TCIC_EDGE_NONE) | ~capture_md[g];
      assign chan_irq[g] = chf_q[g] & cfg_q[g].irq_en;
   end

   assign overflow_irq = ovf_q & ovf_ie_q;

   // ***************************************************
   // read data selection
   // ***************************************************
   wire logic [15:0] cnt_view = cnt_lat_q ? cnt_buf_q : cnt_q;
   wire logic [7:0] sc_view = {ovf_q, ovf_ie_q, center_q, clk_sel_q, ps_sel_q};
   logic [7:0] rd_mux;

   // unmapped offsets read as zero
   always_comb begin
      logic [15:0] v;
      v = TCIC_CNT_ZERO;
      rd_mux = TCIC_BYTE_ZERO;
      if (hit_sc) rd_mux = sc_view;
      if (hit_chi) rd_mux = cnt_view[15:8];
      if (hit_clo) rd_mux = cnt_view[7:0];
      if (hit_mhi) rd_mux = mod_q[15:8];
      if (hit_mlo) rd_mux = mod_q[7:0];
      for (int i = 0; i < TCIC_NUM_CHAN; i++) begin
         v = val_lat_q[i] ? val_buf_q[i] : val_q[i];
         if (hit_csc[i]) rd_mux = {chf_q[i], cfg_q[i], 2'h0};
         if (hit_cvh[i]) rd_mux = v[15:8];
         if (hit_cvl[i]) rd_mux = v[7:0];
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (sys_rst) rdata_q <= TCIC_BYTE_ZERO;
      else rdata_q <= rd ? rd_mux : TCIC_BYTE_ZERO;
   end
   assign rdata = rdata_q;

   // ***************************************************
   // pin synchronisers
   // ***************************************************
   // first stage feeds only the second; edges are taken between stages two and three
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
      end else begin
         pin_s1_q <= chan_pin_in;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // ***************************************************
   // status and control
   // ***************************************************
   // a new overflow beats a clear in the same cycle and disarms the clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ovf_q <= 1'b0;
         ovf_arm_q <= 1'b0;
         ovf_ie_q <= 1'b0;
         center_q <= 1'b0;
         clk_sel_q <= TCIC_CLK_OFF;
         ps_sel_q <= 3'h0;
      end else begin
         if (ovf_evt) ovf_q <= 1'b1;
         else if (sc_wr && ovf_arm_q && !wdata[TCIC_SC_OVF]) ovf_q <= 1'b0;
         if (ovf_evt) ovf_arm_q <= 1'b0;
         else if (rd && hit_sc && ovf_q) ovf_arm_q <= 1'b1;
         else if (sc_wr) ovf_arm_q <= 1'b0;
         if (sc_wr) begin
            ovf_ie_q <= wdata[TCIC_SC_OVF_IE];
            center_q <= wdata[TCIC_SC_CENTER];
            clk_sel_q <= {wdata[TCIC_SC_CLK_HI], wdata[TCIC_SC_CLK_LO]};
            ps_sel_q <= wdata[TCIC_SC_PS_HI:TCIC_SC_PS_LO];
         end
      end
   end

   // ***************************************************
   // prescaler and counter
   // ***************************************************
   // the prescaler is not cleared by a counter write, so the first count may come early
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pre_q <= TCIC_PRE_ZERO;
         cnt_q <= TCIC_CNT_ZERO;
         dir_down_q <= 1'b0;
      end else begin
         if (src_tick) pre_q <= 7'(pre_q + TCIC_PRE_ONE);
         if (cnt_wr) begin
            cnt_q <= TCIC_CNT_ZERO;
            dir_down_q <= 1'b0;
         end else if (cnt_tick) begin
            cnt_q <= cnt_nxt;
            dir_down_q <= dir_nxt;
         end
      end
   end

   // counter read coherency: first byte read freezes both until both are read
   always_ff @(posedge clk) begin
      if (sys_rst || cnt_wr) begin
         cnt_lat_q <= 1'b0;
         cnt_got_q <= TCIC_GOT_NONE;
         cnt_buf_q <= TCIC_CNT_ZERO;
      end else if (cnt_rd) begin
         if (!cnt_lat_q) cnt_buf_q <= cnt_q;
         if ((cnt_got_q | {hit_chi, hit_clo}) == TCIC_GOT_BOTH) begin
            cnt_lat_q <= 1'b0;
            cnt_got_q <= TCIC_GOT_NONE;
         end else begin
            cnt_lat_q <= 1'b1;
            cnt_got_q <= cnt_got_q | {hit_chi, hit_clo};
         end
      end
   end

   // ***************************************************
   // modulus
   // ***************************************************
   // both bytes must arrive before the modulus changes; a status write cancels
   always_ff @(posedge clk) begin
      if (sys_rst || sc_wr) begin
         mod_got_q <= TCIC_GOT_NONE;
         mod_buf_q <= TCIC_CNT_ZERO;
      end else if (wr && (hit_mhi || hit_mlo)) begin
         if (hit_mhi) mod_buf_q[15:8] <= wdata;
         if (hit_mlo) mod_buf_q[7:0] <= wdata;
         if ((mod_got_q | {hit_mhi, hit_mlo}) == TCIC_GOT_BOTH) mod_got_q <= TCIC_GOT_NONE;
         else mod_got_q <= mod_got_q | {hit_mhi, hit_mlo};
      end
   end

   wire logic mod_commit = wr & (hit_mhi | hit_mlo) & ((mod_got_q | {hit_mhi, hit_mlo}) == TCIC_GOT_BOTH);
   wire logic [15:0] mod_new = {hit_mhi ? wdata : mod_buf_q[15:8], hit_mlo ? wdata : mod_buf_q[7:0]};

   always_ff @(posedge clk) begin
      if (sys_rst) mod_q <= TCIC_CNT_ZERO;
      else if (mod_commit) mod_q <= mod_new;
   end

   // ***************************************************
   // channels
   // ***************************************************
   // capture beats a software write to the value in the same cycle
   always_ff @(posedge clk) begin
      for (int i = 0; i < TCIC_NUM_CHAN; i++) begin
         if (sys_rst) begin
            cfg_q[i] <= '0;
            chf_q[i] <= 1'b0;
            ch_arm_q[i] <= 1'b0;
            val_q[i] <= TCIC_CNT_ZERO;
         end else begin
            if (wr && hit_csc[i]) begin
               cfg_q[i].irq_en <= wdata[TCIC_CH_IE];
               cfg_q[i].mode_sel <= wdata[TCIC_CH_MODE_HI:TCIC_CH_MODE_LO];
               cfg_q[i].edge_sel <= wdata[TCIC_CH_EDGE_HI:TCIC_CH_EDGE_LO];
            end
            if (ch_evt[i]) chf_q[i] <= 1'b1;
            else if (wr && hit_csc[i] && ch_arm_q[i] && !wdata[TCIC_CH_FLAG]) chf_q[i] <= 1'b0;
            if (ch_evt[i]) ch_arm_q[i] <= 1'b0;
            else if (rd && hit_csc[i] && chf_q[i]) ch_arm_q[i] <= 1'b1;
            else if (wr && hit_csc[i]) ch_arm_q[i] <= 1'b0;
            if (cap_evt[i]) val_q[i] <= cnt_q;
            else if (wr && hit_cvh[i]) val_q[i][15:8] <= wdata;
            else if (wr && hit_cvl[i]) val_q[i][7:0] <= wdata;
         end
      end
   end

   // channel value read coherency, restarted by a channel control write
   always_ff @(posedge clk) begin
      for (int i = 0; i < TCIC_NUM_CHAN; i++) begin
         if (sys_rst || (wr && hit_csc[i])) begin
            val_lat_q[i] <= 1'b0;
            val_got_q[i] <= TCIC_GOT_NONE;
            val_buf_q[i] <= TCIC_CNT_ZERO;
         end else if (rd && (hit_cvh[i] || hit_cvl[i])) begin
            if (!val_lat_q[i]) val_buf_q[i] <= val_q[i];
            if ((val_got_q[i] | {hit_cvh[i], hit_cvl[i]}) == TCIC_GOT_BOTH) begin
               val_lat_q[i] <= 1'b0;
               val_got_q[i] <= TCIC_GOT_NONE;
            end else begin
               val_lat_q[i] <= 1'b1;
               val_got_q[i] <= val_got_q[i] | {hit_cvh[i], hit_cvl[i]};
            end
         end
      end
   end

endmodule

//--- tcic_timer_props.sv
// checker: port timing relations of the timer with input capture
// assumes it is bound onto tcic_timer and sees one clock domain
`timescale 1ns/1ps
module tcic_timer_props
   import tcic_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire tcic_bus_req_t bus_req,
   input wire logic [7:0] rdata,
   input wire logic [TCIC_NUM_CHAN-1:0] chan_pin_in,
   input wire logic background_active,
   input wire logic stop_mode,
   input wire logic overflow_irq,
   input wire logic [TCIC_NUM_CHAN-1:0] chan_irq,
   input wire logic [TCIC_NUM_CHAN-1:0] chan_pin_own
);
   // ************************************************
   // helper logic and assertions
   // ************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [1:0] held_q;

   // pause length; saturates so a long pause never wraps under the limit
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         held_q <= 2'h0;
      end else if (stop_mode || background_active) begin
         held_q <= held_q + {1'b0, held_q != 2'h3};
      end else begin
         held_q <= 2'h0;
      end
   end

   // outputs idle, pins released, once reset lets go
   a_reset_quiet: assert property ($fell(sys_rst) |-> !overflow_irq && chan_irq == 2'h0 && chan_pin_own == 2'h0)
      else $error("outputs not idle after reset");
   a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
      else $error("read data outside its cycle");
   a_cnt_clear: assert property ((bus_req.wr && (bus_req.addr == TCIC_ADDR_CNT_HI ||
      bus_req.addr == TCIC_ADDR_CNT_LO)) ##2 (bus_req.rd && bus_req.addr == TCIC_ADDR_CNT_HI) |=> rdata == 8'h00)
      else $error("counter not cleared by write");
   // requests only drop through a register write
   a_ovf_hold: assert property (overflow_irq && !bus_req.wr |=> overflow_irq)
      else $error("overflow request dropped without write");
   a_chan_hold: assert property (!bus_req.wr |=> (chan_irq & $past(chan_irq)) == $past(chan_irq))
      else $error("channel request dropped without write");
   a_ovf_paused: assert property ($rose(overflow_irq) |-> held_q < 2'h2 || $past(bus_req.wr))
      else $error("overflow while counting paused");
   a_center_own: assert property (bus_req.wr && bus_req.addr == TCIC_ADDR_SC && bus_req.wdata[TCIC_SC_CENTER]
      |=> chan_pin_own == 2'h3)
      else $error("center mode did not take all pins");
   a_edge_own: assert property (bus_req.wr && bus_req.addr == TCIC_ADDR_CH0 &&
      bus_req.wdata[TCIC_CH_EDGE_HI:TCIC_CH_EDGE_LO] != 2'h0 |=> chan_pin_own[0])
      else $error("capture channel did not take its pin");
endmodule
